/* verilog/rtal_map.vh */
// register map and constants of the result transfer and alert block
//Contract
//- default: all results copy into every result register together at acquisition end
//- any result load sets the result available flag
//- double buffer enabled defers the transfer to next acquisition start
//- manual transfer copies on demand, never while acquisition runs
//- alerts are evaluated and updated before results transfer
//- with oversampling, alerts update once after the last oversample
//- alerts update regardless of transfer, only for enabled measurements
//- per-input voltage alerts need their own over/under enable bits
//- cell over flag sets when voltage strictly above over set threshold
//- cell under flag sets when voltage strictly below under set threshold
//- flags clear only past clear threshold; equality changes nothing; aux flags have no hysteresis and clear at equality
//- summary over/under bits are OR of their per-input flags
//- cell combined alert is OR of its over and under flags
//- spread alert when max minus min exceeds 14-bit threshold
//- spread alert clears when a later difference no longer exceeds
//- spread threshold resets to FFC, which disables the alert; the code still alerts on a spread above FFC
//- report min and max cell indices, highest index on ties
//- total holds 16-bit sum of enabled cell voltages
//- no cells enabled leaves extreme index and total unchanged
//- aux above cold threshold gives cold, below hot gives hot
//- start bit is a strobe that always reads zero
`ifndef RTAL_MAP_VH
`define RTAL_MAP_VH
`define RTAL_OFS_CTRL 8'h00
`define RTAL_OFS_STATUS 8'h04
`define RTAL_OFS_MEAS_EN 8'h08
`define RTAL_OFS_OV_EN 8'h0C
`define RTAL_OFS_UV_EN 8'h10
`define RTAL_OFS_OV_SET 8'h14
`define RTAL_OFS_UV_SET 8'h18
`define RTAL_OFS_OV_CLR 8'h1C
`define RTAL_OFS_UV_CLR 8'h20
`define RTAL_OFS_SPREAD 8'h24
`define RTAL_OFS_HOT 8'h28
`define RTAL_OFS_COLD 8'h2C
`define RTAL_OFS_OV_FLAGS 8'h30
`define RTAL_OFS_UV_FLAGS 8'h34
`define RTAL_OFS_CELL_ALERT 8'h38
`define RTAL_OFS_EXTREME 8'h3C
`define RTAL_OFS_TOTAL 8'h40
`define RTAL_OFS_BLOCK 8'h44
`define RTAL_OFS_DIAGNOSTIC_RESULT_REG 8'h48
`define RTAL_OFS_AUX0 8'h4C
`define RTAL_OFS_AUX1 8'h50
`define RTAL_OFS_CELL0 8'h80
`define RTAL_CTRL_START 0
`define RTAL_CTRL_DBL 1
`define RTAL_CTRL_MOVE 2
`define RTAL_ST_COMPLETE 0
`define RTAL_ST_AVAIL 1
`define RTAL_ST_ANY_OV 2
`define RTAL_ST_ANY_UV 3
`define RTAL_ST_SPREAD 4
`define RTAL_ST_HOT 5
`define RTAL_ST_COLD 6
`define RTAL_EXT_MAX_LSB 8
`define RTAL_RST_OV_SET 16'hFFFF
`define RTAL_RST_UV_SET 16'h0000
`define RTAL_RST_OV_CLR 16'hFFFF
`define RTAL_RST_UV_CLR 16'h0000
`define RTAL_RST_SPREAD 14'h0FFC
`define RTAL_RST_HOT 16'h0000
`define RTAL_RST_COLD 16'hFFFF
`define RTAL_RST_MEAS_EN 14'h3FFF
`endif

/* verilog/rtal_input_alert.v */
// one input's over and under voltage alert flags
`timescale 1ns/10ps
module rtal_input_alert #(
  parameter DW = 16,
  parameter HYST = 1
) (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst_n,
  // evaluation control
  input wire i_eval,
  input wire i_ov_en,
  input wire i_uv_en,
  // sample and thresholds
  input wire [DW-1:0] i_value,
  input wire [DW-1:0] i_ov_set,
  input wire [DW-1:0] i_ov_clr,
  input wire [DW-1:0] i_uv_set,
  input wire [DW-1:0] i_uv_clr,
  // flags
  output reg o_ov_q,
  output reg o_uv_q
);
  reg ov_d;
  reg uv_d;

  always @* begin
    ov_d = o_ov_q;
    uv_d = o_uv_q;
    if (HYST != 0) begin
      // over set, clear past clear level
      if (i_value > i_ov_set)
        ov_d = 1'b1;
      else if (i_value < i_ov_clr)
        ov_d = 1'b0;
      // under set, clear past clear level
      if (i_value < i_uv_set)
        uv_d = 1'b1;
      else if (i_value > i_uv_clr)
        uv_d = 1'b0;
    end else begin
      ov_d = i_value > i_ov_set;
      uv_d = i_value < i_uv_set;
    end
  end

  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_ov_q <= 1'b0;
      o_uv_q <= 1'b0;
    end else if (i_eval) begin
      // each flag only moves when enabled at evaluation
      if (i_ov_en)
        o_ov_q <= ov_d;
      if (i_uv_en)
        o_uv_q <= uv_d;
    end
  end
endmodule

/* verilog/rtal_core.v */
// result transfer, alert evaluation and apb register file
`timescale 1ns/10ps
`include "rtal_map.vh"
module rtal_core #(
  parameter NCELL = 12,
  parameter NAUX = 2,
  parameter DW = 16
) (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst_n,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg o_pready,
  output reg [31:0] o_prdata,
  output reg o_pslverr,
  // arithmetic unit results, stable after i_alu_done
  input wire [NCELL*DW-1:0] i_alu_cell,
  input wire [NAUX*DW-1:0] i_alu_aux,
  input wire [DW-1:0] i_alu_block,
  input wire [DW-1:0] i_alu_diagnostic_result_reg,
  // acquisition sequencer
  input wire i_alu_done,
  output reg o_acq_start,
  output reg o_acq_busy,
  output reg o_result_available
);
  localparam NIN = NCELL + NAUX;
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_ACQ = 3'b010;
  localparam [2:0] S_XFER = 3'b100;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg double_buffer_enable_q;
  reg acq_complete_q;
  reg xfer_pending_q;
  reg [NIN-1:0] measurement_enable_q;
  reg [NIN-1:0] overvolt_alert_enable_q;
  reg [NIN-1:0] undervolt_alert_enable_q;
  reg [DW-1:0] ov_set_q;
  reg [DW-1:0] uv_set_q;
  reg [DW-1:0] ov_clr_q;
  reg [DW-1:0] uv_clr_q;
  reg [13:0] spread_threshold_q;
  reg [DW-1:0] hot_threshold_q;
  reg [DW-1:0] cold_threshold_q;
  reg spread_alert_q;
  reg [NCELL*DW-1:0] cell_result_q;
  reg [NAUX*DW-1:0] aux_result_q;
  reg [DW-1:0] block_result_q;
  reg [DW-1:0] diagnostic_result_reg_result_q;
  reg [DW-1:0] total_q;
  reg [3:0] min_idx_q;
  reg [3:0] max_idx_q;

  wire [NIN-1:0] ov_flags;
  wire [NIN-1:0] uv_flags;
  wire [NIN*DW-1:0] alu_in = {i_alu_aux, i_alu_cell};
  wire bus_setup = i_psel & ~i_penable;
  wire wr_fire = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr;
  wire [NCELL-1:0] cell_en = measurement_enable_q[NCELL-1:0];
  wire any_cell = |cell_en;
  wire eval = (state_q == S_ACQ) & i_alu_done;
  wire wr_ctrl = wr_fire & (i_paddr == `RTAL_OFS_CTRL);
  wire start_req = wr_ctrl & i_pwdata[`RTAL_CTRL_START];
  wire move_req = wr_ctrl & i_pwdata[`RTAL_CTRL_MOVE];
  reg do_xfer;

  // per-input alert flags, aux inputs without hysteresis
  genvar g;
  generate
    for (g = 0; g < NIN; g = g + 1) begin : g_in
      rtal_input_alert #(
        .DW(DW),
        .HYST(g < NCELL ? 1 : 0)
      ) u_alert (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_eval(eval & measurement_enable_q[g]),
        .i_ov_en(overvolt_alert_enable_q[g]),
        .i_uv_en(undervolt_alert_enable_q[g]),
        .i_value(alu_in[g*DW +: DW]),
        .i_ov_set(g < NCELL ? ov_set_q : cold_threshold_q),
        .i_ov_clr(ov_clr_q),
        .i_uv_set(g < NCELL ? uv_set_q : hot_threshold_q),
        .i_uv_clr(uv_clr_q),
        .o_ov_q(ov_flags[g]),
        .o_uv_q(uv_flags[g])
      );
    end
  endgenerate

  // cell statistics over the enabled cells
  reg [DW-1:0] min_v;
  reg [DW-1:0] max_v;
  reg [3:0] min_i;
  reg [3:0] max_i;
  reg [DW-1:0] sum_v;
  reg seen;
  integer i;
  always @* begin
    min_v = {DW{1'b1}};
    max_v = {DW{1'b0}};
    min_i = 4'h0;
    max_i = 4'h0;
    sum_v = {DW{1'b0}};
    seen = 1'b0;
    for (i = 0; i < NCELL; i = i + 1) begin
      if (cell_en[i]) begin
        // ascending scan with <= and >= keeps the highest tie
        if (!seen || i_alu_cell[i*DW +: DW] <= min_v) begin
          min_v = i_alu_cell[i*DW +: DW];
          min_i = i[3:0];
        end
        if (!seen || i_alu_cell[i*DW +: DW] >= max_v) begin
          max_v = i_alu_cell[i*DW +: DW];
          max_i = i[3:0];
        end
        sum_v = sum_v + i_alu_cell[i*DW +: DW];
        seen = 1'b1;
      end
    end
  end
  wire [DW-1:0] spread_v = max_v - min_v;

  // transfer decision: auto, deferred, or manual
  always @* begin
    state_d = state_q;
    do_xfer = 1'b0;
    case (state_q)
      S_IDLE: begin
        if (start_req) begin
          state_d = S_ACQ;
          // deferred transfer lands at the next start
          do_xfer = xfer_pending_q;
        end else if (move_req) begin
          // manual copy only outside an acquisition
          do_xfer = 1'b1;
        end
      end
      S_ACQ: begin
        // flags update this cycle, copy follows next cycle
        if (i_alu_done)
          state_d = S_XFER;
      end
      S_XFER: begin
        state_d = S_IDLE;
        // default parallel load at acquisition end
        do_xfer = ~double_buffer_enable_q;
      end
      default: state_d = S_IDLE;
    endcase
  end

  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_q <= S_IDLE;
      xfer_pending_q <= 1'b0;
      acq_complete_q <= 1'b0;
      o_acq_start <= 1'b0;
      o_acq_busy <= 1'b0;
    end else begin
      state_q <= state_d;
      // start is a strobe toward the sequencer
      o_acq_start <= (state_q == S_IDLE) & start_req;
      o_acq_busy <= state_d != S_IDLE;
      if ((state_q == S_IDLE) & start_req)
        acq_complete_q <= 1'b0;
      else if (state_q == S_XFER)
        acq_complete_q <= 1'b1;
      if (do_xfer)
        xfer_pending_q <= 1'b0;
      else if ((state_q == S_XFER) & double_buffer_enable_q)
        xfer_pending_q <= 1'b1;
    end
  end

  // result registers, all loaded in the same cycle
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cell_result_q <= {NCELL*DW{1'b0}};
      aux_result_q <= {NAUX*DW{1'b0}};
      block_result_q <= {DW{1'b0}};
      diagnostic_result_reg_result_q <= {DW{1'b0}};
      total_q <= {DW{1'b0}};
      min_idx_q <= 4'h0;
      max_idx_q <= 4'h0;
    end else if (do_xfer) begin
      // every result register in one load
      cell_result_q <= i_alu_cell;
      aux_result_q <= i_alu_aux;
      block_result_q <= i_alu_block;
      diagnostic_result_reg_result_q <= i_alu_diagnostic_result_reg;
      // statistics kept when no cell was measured
      if (any_cell) begin
        total_q <= sum_v;
        min_idx_q <= min_i;
        max_idx_q <= max_i;
      end
    end
  end

  // result available: set on load, cleared by writing one
  always @(posedge i_core_clk) begin
    if (!i_rst_n)
      o_result_available <= 1'b0;
    // set wins over a same-cycle clear
    else if (do_xfer)
      o_result_available <= 1'b1;
    else if (wr_fire & (i_paddr == `RTAL_OFS_STATUS) & i_pwdata[`RTAL_ST_AVAIL])
      o_result_available <= 1'b0;
  end

  // spread alert follows each evaluation with cells enabled
  always @(posedge i_core_clk) begin
    if (!i_rst_n)
      spread_alert_q <= 1'b0;
    else if (eval & any_cell)
      spread_alert_q <= spread_v > {{(DW-14){1'b0}}, spread_threshold_q};
  end

  // software-written configuration
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      double_buffer_enable_q <= 1'b0;
      measurement_enable_q <= `RTAL_RST_MEAS_EN;
      overvolt_alert_enable_q <= {NIN{1'b0}};
      undervolt_alert_enable_q <= {NIN{1'b0}};
      ov_set_q <= `RTAL_RST_OV_SET;
      uv_set_q <= `RTAL_RST_UV_SET;
      ov_clr_q <= `RTAL_RST_OV_CLR;
      uv_clr_q <= `RTAL_RST_UV_CLR;
      // reset value 0FFC leaves the spread alert active for spreads above 0FFC
      spread_threshold_q <= `RTAL_RST_SPREAD;
      hot_threshold_q <= `RTAL_RST_HOT;
      cold_threshold_q <= `RTAL_RST_COLD;
    end else if (wr_fire) begin
      if (i_paddr == `RTAL_OFS_CTRL)
        double_buffer_enable_q <= i_pwdata[`RTAL_CTRL_DBL];
      else if (i_paddr == `RTAL_OFS_MEAS_EN)
        measurement_enable_q <= i_pwdata[NIN-1:0];
      else if (i_paddr == `RTAL_OFS_OV_EN)
        overvolt_alert_enable_q <= i_pwdata[NIN-1:0];
      else if (i_paddr == `RTAL_OFS_UV_EN)
        undervolt_alert_enable_q <= i_pwdata[NIN-1:0];
      else if (i_paddr == `RTAL_OFS_OV_SET)
        ov_set_q <= i_pwdata[DW-1:0];
      else if (i_paddr == `RTAL_OFS_UV_SET)
        uv_set_q <= i_pwdata[DW-1:0];
      else if (i_paddr == `RTAL_OFS_OV_CLR)
        ov_clr_q <= i_pwdata[DW-1:0];
      else if (i_paddr == `RTAL_OFS_UV_CLR)
        uv_clr_q <= i_pwdata[DW-1:0];
      else if (i_paddr == `RTAL_OFS_SPREAD)
        spread_threshold_q <= i_pwdata[13:0];
      else if (i_paddr == `RTAL_OFS_HOT)
        hot_threshold_q <= i_pwdata[DW-1:0];
      else if (i_paddr == `RTAL_OFS_COLD)
        cold_threshold_q <= i_pwdata[DW-1:0];
    end
  end

  // read decode; unmapped addresses answer with pslverr
  reg [31:0] rd_d;
  reg err_d;
  wire [3:0] cell_sel = i_paddr[5:2];
  always @* begin
    rd_d = 32'h0000_0000;
    err_d = 1'b0;
    if (i_paddr[1:0] != 2'b00)
      err_d = 1'b1;
    else if (i_paddr == `RTAL_OFS_CTRL)
      // start and move strobes read back as zero
      rd_d[`RTAL_CTRL_DBL] = double_buffer_enable_q;
    else if (i_paddr == `RTAL_OFS_STATUS) begin
      rd_d[`RTAL_ST_COMPLETE] = acq_complete_q;
      rd_d[`RTAL_ST_AVAIL] = o_result_available;
      rd_d[`RTAL_ST_ANY_OV] = |ov_flags;
      rd_d[`RTAL_ST_ANY_UV] = |uv_flags;
      rd_d[`RTAL_ST_SPREAD] = spread_alert_q;
      // aux flags form the temperature alerts
      rd_d[`RTAL_ST_HOT] = |uv_flags[NIN-1:NCELL];
      rd_d[`RTAL_ST_COLD] = |ov_flags[NIN-1:NCELL];
    end else if (i_paddr == `RTAL_OFS_MEAS_EN)
      rd_d[NIN-1:0] = measurement_enable_q;
    else if (i_paddr == `RTAL_OFS_OV_EN)
      rd_d[NIN-1:0] = overvolt_alert_enable_q;
    else if (i_paddr == `RTAL_OFS_UV_EN)
      rd_d[NIN-1:0] = undervolt_alert_enable_q;
    else if (i_paddr == `RTAL_OFS_OV_SET)
      rd_d[DW-1:0] = ov_set_q;
    else if (i_paddr == `RTAL_OFS_UV_SET)
      rd_d[DW-1:0] = uv_set_q;
    else if (i_paddr == `RTAL_OFS_OV_CLR)
      rd_d[DW-1:0] = ov_clr_q;
    else if (i_paddr == `RTAL_OFS_UV_CLR)
      rd_d[DW-1:0] = uv_clr_q;
    else if (i_paddr == `RTAL_OFS_SPREAD)
      rd_d[13:0] = spread_threshold_q;
    else if (i_paddr == `RTAL_OFS_HOT)
      rd_d[DW-1:0] = hot_threshold_q;
    else if (i_paddr == `RTAL_OFS_COLD)
      rd_d[DW-1:0] = cold_threshold_q;
    else if (i_paddr == `RTAL_OFS_OV_FLAGS)
      rd_d[NIN-1:0] = ov_flags;
    else if (i_paddr == `RTAL_OFS_UV_FLAGS)
      rd_d[NIN-1:0] = uv_flags;
    else if (i_paddr == `RTAL_OFS_CELL_ALERT)
      rd_d[NCELL-1:0] = ov_flags[NCELL-1:0] | uv_flags[NCELL-1:0];
    else if (i_paddr == `RTAL_OFS_EXTREME) begin
      rd_d[3:0] = min_idx_q;
      rd_d[`RTAL_EXT_MAX_LSB +: 4] = max_idx_q;
    end else if (i_paddr == `RTAL_OFS_TOTAL)
      rd_d[DW-1:0] = total_q;
    else if (i_paddr == `RTAL_OFS_BLOCK)
      rd_d[DW-1:0] = block_result_q;
    else if (i_paddr == `RTAL_OFS_DIAGNOSTIC_RESULT_REG)
      rd_d[DW-1:0] = diagnostic_result_reg_result_q;
    else if (i_paddr == `RTAL_OFS_AUX0)
      rd_d[DW-1:0] = aux_result_q[0 +: DW];
    else if (i_paddr == `RTAL_OFS_AUX1)
      rd_d[DW-1:0] = aux_result_q[DW +: DW];
    else if ((i_paddr[7:6] == 2'b10) && ({28'h0, cell_sel} < NCELL))
      rd_d[DW-1:0] = cell_result_q[cell_sel*DW +: DW];
    else
      err_d = 1'b1;
  end

  // zero-wait apb: answer registered in setup, shown in access
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= bus_setup;
      o_pslverr <= bus_setup & err_d;
      if (bus_setup & ~i_pwrite)
        o_prdata <= rd_d;
    end
  end
endmodule

/* tb/rtal_core_checker.sv */
// concurrent checks on the result transfer core ports
`timescale 1ns/10ps
module rtal_core_checker (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst_n,
  // apb
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire o_pready,
  input wire [31:0] o_prdata,
  input wire o_pslverr,
  // sequencer
  input wire i_alu_done,
  input wire o_acq_start,
  input wire o_acq_busy,
  input wire o_result_available
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  wire setup = i_psel && !i_penable;
  wire wr = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;
  wire ctl = wr && i_paddr == 8'h00;
  wire go = ctl && i_pwdata[0];
  wire mv = ctl && i_pwdata[2] && !i_pwdata[0];
  wire fin = o_acq_busy && i_alu_done;
  reg dbl_q;
  always @(posedge i_core_clk) begin
    dbl_q <= !i_rst_n ? 1'b0 : ctl ? i_pwdata[1] : dbl_q;
  end
  a_one_wait: assert property (setup |=> o_pready ##1 !o_pready)
    else $error("apb answer not one cycle");
  a_bad_addr: assert property (setup && !i_pwrite && i_paddr > 8'hAC |=> o_pslverr && !o_prdata)
    else $error("unmapped read not refused");
  a_start_strobe: assert property (go && !o_acq_busy |=> o_acq_start && o_acq_busy ##1 !o_acq_start)
    else $error("start strobe wrong");
  a_start_busy: assert property (go && o_acq_busy |=> !o_acq_start)
    else $error("start taken while busy");
  a_ctrl_zero: assert property (setup && !i_pwrite && i_paddr == 8'h00 |=> !o_prdata[0] && !o_prdata[2])
    else $error("start bit reads one");
  a_auto_xfer: assert property (fin && !dbl_q |-> ##[1:2] o_result_available)
    else $error("no transfer after acquisition");
  a_dbl_defer: assert property (fin && dbl_q && !o_result_available |=> !o_result_available [*2])
    else $error("transfer not deferred");
  a_busy_ends: assert property (fin |-> ##[1:2] !o_acq_busy)
    else $error("busy did not end");
  a_move_idle: assert property (mv && !o_acq_busy |=> o_result_available)
    else $error("manual move ignored");
  a_move_busy: assert property (mv && o_acq_busy && !o_result_available && !$past(i_alu_done)
    |=> !o_result_available)
    else $error("manual move taken while busy");
  a_avail_holds: assert property (o_result_available && !(wr && i_paddr == 8'h04 && i_pwdata[1])
    |=> o_result_available)
    else $error("result flag dropped");
  c_acq: cover property (fin);
  c_err: cover property (o_pready && o_pslverr);
  c_dbl: cover property (go && dbl_q);
endmodule
bind rtal_core rtal_core_checker i_rtal_core_checker (.i_core_clk, .i_rst_n, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .i_alu_done, .o_acq_start,
  .o_acq_busy, .o_result_available);

/* tb/rtal_seq_model.sv */
// acquisition sequencer and arithmetic unit stand-in
`timescale 1ns/10ps
module rtal_seq_model #(
  parameter LAT = 40
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_start,
  input wire [255:0] i_next,
  output reg o_done,
  output reg [255:0] o_res
);
  reg [7:0] cnt_q;
  always @(posedge i_core_clk) begin
    o_done <= 1'b0;
    if (!i_rst_n) begin
      cnt_q <= 8'h00;
      o_res <= 256'h0;
    end else if (i_start) begin
      cnt_q <= 8'(LAT);
      // accumulators churn while converting, so early copies show junk
      o_res <= ~o_res;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
      if (cnt_q == 8'h01) begin
        o_done <= 1'b1;
        o_res <= i_next;
      end
    end
  end
endmodule

/* tb/rtal_core_tb.sv */
// self-checking bench for the result transfer and alert core
`timescale 1ns/10ps
module rtal_core_tb;
  typedef struct packed {logic [31:0] ex; logic [31:0] m; logic e;} rtal_note_t;
  reg clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg [255:0] nxt = 256'h0;
  wire pready, pslverr, start, busy, avail, done;
  wire [31:0] prdata;
  wire [255:0] res;
  rtal_note_t q[$];
  int n_fail = 0, checked = 0;
  logic [15:0] cv[14], th[7], tot = 0, blk, dg;
  logic [13:0] ovf = 0, uvf = 0, men, oven, uven;
  logic [11:0] ext = 0;
  logic spr = 0;
  rtal_core i_rtal_core (.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_alu_cell(res[191:0]), .i_alu_aux(res[223:192]),
    .i_alu_block(res[239:224]), .i_alu_diagnostic_result_reg(res[255:240]), .i_alu_done(done),
    .o_acq_start(start), .o_acq_busy(busy), .o_result_available(avail));
  rtal_seq_model i_rtal_seq_model (.i_core_clk(clk), .i_rst_n(rst_n), .i_start(start),
    .i_next(nxt), .o_done(done), .o_res(res));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (psel && pen && pready) begin
      checked++;
      if (q.size() == 0 || ((prdata ^ q[0].ex) & q[0].m) !== 32'h0 || pslverr !== q[0].e) begin
        n_fail++;
        $display("MISMATCH %0t addr %h data %h", $time, paddr, prdata);
      end
      if (q.size() != 0) void'(q.pop_front());
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] ex, input logic [31:0] m, input logic e, output logic [31:0] r);
    int k;
    @(posedge clk);
    q.push_back('{ex, m, e});
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) n_fail++;
    r = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, ex, 32'hFFFFFFFF, 1'b0, r);
  endtask
  task automatic wait_done;
    logic [31:0] r;
    int k;
    r = 32'h0;
    for (k = 0; k < 60 && r[0] !== 1'b1; k++) apb(1'b0, 8'h04, 32'h0, 32'h0, 32'h0, 1'b0, r);
    if (r[0] !== 1'b1) begin
      n_fail++;
      $display("MISMATCH %0t acquisition never completed", $time);
    end
  endtask
  task automatic predict;
    logic [15:0] mn, mx, t;
    int i;
    mn = 16'hFFFF;
    mx = 16'h0000;
    t = 16'h0000;
    for (i = 0; i < 14; i++) begin
      if (men[i] && oven[i]) ovf[i] = i < 12 ? (cv[i] > th[0] ? 1'b1 : cv[i] < th[2] ? 1'b0 : ovf[i])
        : cv[i] > th[6];
      if (men[i] && uven[i]) uvf[i] = i < 12 ? (cv[i] < th[1] ? 1'b1 : cv[i] > th[3] ? 1'b0 : uvf[i])
        : cv[i] < th[5];
      if (i < 12 && men[i]) begin
        if (cv[i] <= mn) ext[3:0] = 4'(i);
        if (cv[i] <= mn) mn = cv[i];
        if (cv[i] >= mx) ext[11:8] = 4'(i);
        if (cv[i] >= mx) mx = cv[i];
        t = t + cv[i];
      end
    end
    if (men[11:0] != 12'h000) tot = t;
    if (men[11:0] != 12'h000) spr = (mx - mn) > th[4];
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #(5 * 20000);
    n_fail++;
    conclude;
  end
  initial begin
    logic [31:0] r, s;
    logic [15:0] v0, v1;
    int k, i;
    void'($urandom(37));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h24, 32'h0FFC);
    rd(8'h14, 32'hFFFF);
    rd(8'h2C, 32'hFFFF);
    rd(8'h08, 32'h3FFF);
    rd(8'h00, 32'h0);
    apb(1'b1, 8'h0D, 32'hFFF, 32'h0, 32'h0, 1'b1, r);
    apb(1'b0, 8'hFC, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1, r);
    rd(8'h0C, 32'h0);
    for (k = 0; k < 8; k++) begin
      men = k == 0 ? 14'h3FFF : k % 4 == 1 ? 14'h3000 : 14'($urandom);
      oven = 14'($urandom);
      uven = 14'($urandom);
      th[0] = 16'(3002 + $urandom % 4);
      th[2] = th[0] - 16'($urandom % 3);
      th[1] = 16'(3001 + $urandom % 4);
      th[3] = th[1] + 16'($urandom % 3);
      th[4] = 16'($urandom % 9);
      th[5] = 16'(3000 + $urandom % 8);
      th[6] = 16'(3000 + $urandom % 8);
      for (i = 0; i < 14; i++) cv[i] = 16'(3000 + $urandom % 8);
      blk = 16'($urandom);
      dg = 16'($urandom);
      wr(8'h08, 32'(men));
      wr(8'h0C, 32'(oven));
      wr(8'h10, 32'(uven));
      for (i = 0; i < 7; i++) wr(8'(8'h14 + 4 * i), 32'(th[i]));
      for (i = 0; i < 7; i++) rd(8'(8'h14 + 4 * i), 32'(th[i]));
      rd(8'h10, 32'(uven));
      for (i = 0; i < 14; i++) nxt[16*i +: 16] = cv[i];
      nxt[255:224] = {dg, blk};
      wr(8'h00, 32'h1);
      wait_done;
      predict;
      s = {25'h0, |ovf[13:12], |uvf[13:12], spr, |uvf, |ovf, 2'b11};
      rd(8'h04, s);
      rd(8'h30, 32'(ovf));
      rd(8'h34, 32'(uvf));
      apb(1'b0, 8'h38, 32'h0, 32'(ovf | uvf), 32'hFFF, 1'b0, r);
      rd(8'h3C, 32'(ext));
      rd(8'h40, 32'(tot));
      rd(8'h44, 32'(blk));
      rd(8'h48, 32'(dg));
      for (i = 0; i < 14; i++) rd(8'(i < 12 ? 8'h80 + 4 * i : 8'h4C + 4 * (i - 12)), 32'(cv[i]));
      wr(8'h04, 32'h2);
      rd(8'h04, s & ~32'h2);
    end
    v0 = cv[0];
    v1 = v0 ^ 16'h0100;
    nxt[15:0] = v1;
    wr(8'h00, 32'h2);
    wr(8'h00, 32'h3);
    wr(8'h04, 32'h2);
    wait_done;
    rd(8'h80, 32'(v0));
    wr(8'h00, 32'h6);
    rd(8'h80, 32'(v1));
    nxt[15:0] = v0;
    wr(8'h00, 32'h3);
    wr(8'h04, 32'h2);
    wr(8'h00, 32'h6);
    wr(8'h00, 32'h3);
    rd(8'h80, 32'(v1));
    wait_done;
    rd(8'h80, 32'(v1));
    wr(8'h00, 32'h3);
    rd(8'h80, 32'(v0));
    wait_done;
    conclude;
  end
endmodule
